// [src/vbd_pkg.sv]
// Constants, carrier types and state types of the video back-end datapath.
// Summary of operation
// - Line store: 852 entries, 12 bits, recirculating
// - Store restarts with window, holds after 852
// - 4:1:1 nibbles become sequential half-rate U/V
// - Mixer output is k/4 times (A-B) plus B
// - Accumulate upper-nibble luma difference in active video
// - Strobe rise in blanking copies top accumulator bytes
// - Host read of the high byte clears the correlation register
// - 26-tap chroma line, slope-driven tap select
// - U/V share path; interpolate adjacent selected taps
// - Force blanking levels while blanking input low
// - Grey level outside window without repetition
// - With repetition hold last values outside window
// - Read enables delayed 5-8 clocks; zoom modifies first
// - Feedback bus is first-field bus delayed four
// - Blanking rise fixes chroma phase; 0-3 delay
// - Strobe high three-states the feedback bus
// - Host makes serial clock; data valid rising
// - Eight address bits, then eight data, LSB first
// - Strobe high clears address; after its fall next bit LSB
package vbd_pkg;

  localparam int LINE_LEN   = 852;
  localparam int LINE_W     = 12;
  localparam int CTI_TAPS   = 26;
  localparam int CTI_CENTER = 12;
  localparam int RE_BASE    = 5;
  localparam int RE_SHIFT   = 8;
  localparam int FB_DELAY   = 4;
  localparam int BLN_SHIFT  = 3;
  localparam int ACC_W      = 24;

  localparam logic [7:0] ADDR_FMT  = 8'h01;
  localparam logic [7:0] ADDR_GREY = 8'h02;
  localparam logic [7:0] ADDR_RE   = 8'h03;
  localparam logic [7:0] ADDR_ZOOM = 8'h04;
  localparam logic [7:0] ADDR_CTI  = 8'h05;
  localparam logic [7:0] ADDR_PEAK = 8'h06;
  localparam logic [7:0] ADDR_MUX  = 8'h7C;
  localparam logic [7:0] ADDR_CLO  = 8'h80;
  localparam logic [7:0] ADDR_CHI  = 8'h81;

  localparam logic [7:0] MASK_FMT  = 8'hFC;
  localparam logic [7:0] MASK_GREY = 8'hF0;
  localparam logic [7:0] MASK_CTI  = 8'hF0;
  localparam logic [7:0] REG_RST   = 8'h00;
  localparam logic [7:0] BLACK_HI  = 8'h10;

  localparam int FMT_FEEDBACK = 7;
  localparam int RE1_D_LSB    = 0;
  localparam int RE_INV1      = 2;
  localparam int RE2_D_LSB    = 3;
  localparam int RE_INV2      = 5;
  localparam int BLN_D_LSB    = 6;
  localparam int ZM_PIXREP    = 1;
  localparam int ZM_BLACK16   = 2;
  localparam int ZM_LSB       = 3;
  localparam int CTI_RANGE    = 4;
  localparam int CTI_GAIN     = 6;

  typedef struct packed {
    logic [7:0] y;
    logic [3:0] uv;
  } vbd_pix_t;

  typedef struct packed {
    logic [7:0] y;
    logic [7:0] u;
    logic [7:0] v;
  } vbd_yuv_t;

  typedef struct packed {
    logic [7:0] fmt, grey, reTim, zoom, cti, peak;
    logic       fieldOneSel, medianSel;
  } vbd_ctrl_t;

  typedef struct packed {
    logic [3:0] bitCnt;
    logic [7:0] addr, data, tx, wrAddr, wrData;
    logic       isRead, oe, wrTgl, rdTgl;
  } vbd_link_t;

  typedef struct packed {
    vbd_ctrl_t                     ctrl;
    logic [2:0]                    wrSync, rdSync, rstrSync;
    logic [BLN_SHIFT-1:0]          blnDly;
    logic                          blnPrev, winPrev, skipLine;
    logic [RE_SHIFT-1:0]           re1Sh, re2Sh;
    logic [9:0]                    linePtr;
    logic [4:0]                    zoomAcc;
    logic [1:0]                    phase;
    logic [1:0][7:0]               uAcc, vAcc, uHold, vHold;
    vbd_pix_t                      pixDly;
    logic [7:0]                    yMix, uCti, vCti;
    logic [CTI_TAPS-1:0][7:0]      taps;
    logic [8:0]                    dPrev;
    logic [ACC_W-1:0]              acc;
    logic [15:0]                   corr;
    logic [FB_DELAY-1:0][LINE_W-1:0] fbPipe;
    vbd_yuv_t                      out;
  } vbd_core_t;

endpackage : vbd_pkg

// [src/vbd_backend.sv]
// Video back-end datapath with its serial host link.
`timescale 1ns/1ps
module vbd_backend (
  input  wire logic          core_clk,
  input  wire logic          arst_n,
  input  wire logic          hostSerialClock,
  input  wire logic          hostSerialDataIn,
  output logic               hostSerialDataOut,
  output logic               hostSerialDataOe,
  input  wire logic          linkResetStrobe,
  input  wire logic          blankN,
  input  wire logic          bank1ReadReqIn,
  input  wire logic          bank2ReadReqIn,
  output logic               bank1ReadReqOut,
  output logic               bank2ReadReqOut,
  input  wire vbd_pkg::vbd_pix_t field1Bus,
  input  wire vbd_pkg::vbd_pix_t field2Bus,
  output vbd_pkg::vbd_pix_t  feedbackBus,
  output logic               feedbackOe,
  output vbd_pkg::vbd_yuv_t  videoOut
);
  import vbd_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  vbd_core_t         r, c;
  vbd_link_t         lr, ln;
  logic [LINE_W-1:0] lineMem [LINE_LEN];
  vbd_pix_t          lineRd;
  vbd_pix_t          inPix;
  logic              linkRstN, blnInt, blnRise, win, winRise, storeEn;
  logic              wrEvent, rdEvent, rstrRise;
  logic [2:0]        kCoef, re1Idx, re2Idx;
  logic [3:0]        lumaDiff;
  logic [1:0][7:0]   uvSeq;
  logic [7:0]        fullAddr;

  // Absolute difference of two bytes.
  function automatic logic [7:0] absDiff(input logic [7:0] a, input logic [7:0] b);
    absDiff = (a > b) ? 8'(a - b) : 8'(b - a);
  endfunction : absDiff

  // Mixer: b + k/4 * (a - b), with k in quarters from 0 to 4.
  function automatic logic [7:0] mixF(input logic [7:0] a, input logic [7:0] b,
                                      input logic [2:0] k);
    logic signed [11:0] d;
    logic        [11:0] s;
    d = ($signed({4'h0, a}) - $signed({4'h0, b})) * $signed({9'h000, k});
    s = {4'h0, b} + 12'(d >>> 2);
    mixF = s[7:0];
  endfunction : mixF

  // Refuse a line length that the 10-bit line pointer cannot count.
  if (LINE_LEN > 1023) begin : g_len_chk
    $error("line length exceeds pointer range");
  end

  // ----------------------------------------------------------------
  // Host serial link, clocked by the host's own serial clock
  // ----------------------------------------------------------------
  // The strobe holds the link in reset, so its fall restarts at the address LSB.
  assign linkRstN = arst_n & ~linkResetStrobe;
  assign fullAddr = {hostSerialDataIn, lr.addr[7:1]};

  // Shifts address then data, LSB first, one bit per rising serial edge.
  always_comb begin
    ln = lr;
    ln.bitCnt = lr.bitCnt + 4'h1;
    if (lr.bitCnt < 4'h8) begin
      ln.addr = fullAddr;
      if (lr.bitCnt == 4'h7) begin
        ln.isRead = fullAddr[7];
        if (fullAddr[7]) begin
          // The correlation word only changes while the link is idle or held.
          ln.tx = (fullAddr == ADDR_CHI) ? r.corr[15:8] : r.corr[7:0];
          ln.oe = 1'b1;
        end else if (fullAddr[7:2] == ADDR_MUX[7:2]) begin
          ln.wrAddr = fullAddr;
          ln.wrTgl  = ~lr.wrTgl;
        end
      end
    end else if (lr.isRead) begin
      ln.tx = {1'b0, lr.tx[7:1]};
      if (lr.bitCnt == 4'hF) begin
        ln.oe = 1'b0;
        if (lr.addr == ADDR_CHI) begin
          ln.rdTgl = ~lr.rdTgl;
        end
      end
    end else begin
      ln.data = {hostSerialDataIn, lr.data[7:1]};
      if (lr.bitCnt == 4'hF && lr.addr[7:2] != ADDR_MUX[7:2]) begin
        ln.wrAddr = lr.addr;
        ln.wrData = {hostSerialDataIn, lr.data[7:1]};
        ln.wrTgl  = ~lr.wrTgl;
      end
    end
  end

  // Link state register.
  always_ff @(posedge hostSerialClock or negedge linkRstN) begin
    if (!linkRstN) begin
      lr <= '0;
    end else begin
      lr <= ln;
    end
  end

  assign hostSerialDataOut = lr.tx[0];
  assign hostSerialDataOe  = lr.oe;

  // ----------------------------------------------------------------
  // Core timing: strobe, blanking and read-enable processing
  // ----------------------------------------------------------------
  assign wrEvent  = r.wrSync[2] ^ r.wrSync[1];
  assign rdEvent  = r.rdSync[2] ^ r.rdSync[1];
  assign rstrRise = r.rstrSync[1] & ~r.rstrSync[2];
  assign blnInt   = (r.ctrl.reTim[BLN_D_LSB +: 2] == 2'd0) ? blankN
                  : r.blnDly[r.ctrl.reTim[BLN_D_LSB +: 2] - 2'd1];
  assign blnRise  = blnInt & ~r.blnPrev;
  assign win      = r.re1Sh[RE_BASE-1];
  assign winRise  = win & ~r.winPrev;
  assign re1Idx   = 3'(RE_BASE - 1) + {1'b0, r.ctrl.reTim[RE1_D_LSB +: 2]};
  assign re2Idx   = 3'(RE_BASE - 1) + {1'b0, r.ctrl.reTim[RE2_D_LSB +: 2]};

  // Delayed read enables; a repeated zoom line suppresses bank one.
  assign bank1ReadReqOut = (r.re1Sh[re1Idx] & ~r.skipLine) ^ r.ctrl.reTim[RE_INV1];
  assign bank2ReadReqOut = r.re2Sh[re2Idx] ^ r.ctrl.reTim[RE_INV2];

  // Feedback bus; the strobe overrides the enable at once.
  assign feedbackBus = r.fbPipe[FB_DELAY-1];
  assign feedbackOe  = r.ctrl.fmt[FMT_FEEDBACK] & ~linkResetStrobe;
  assign videoOut    = r.out;

  // ----------------------------------------------------------------
  // Line store and mixing coefficient
  // ----------------------------------------------------------------
  assign inPix   = r.ctrl.fieldOneSel ? field1Bus : field2Bus;
  assign storeEn = win && (r.linePtr < 10'(LINE_LEN));
  assign kCoef   = r.skipLine ? 3'd0
                 : (r.ctrl.zoom[ZM_LSB +: 5] == 5'd0) ? 3'd4
                 : 3'd4 - {1'b0, r.zoomAcc[4:3]};

  // Shift-register store; skipping the write recirculates the old line.
  always_ff @(posedge core_clk) begin
    // The pointer rests one past the last entry, so the read index is clamped.
    lineRd <= lineMem[(r.linePtr < 10'(LINE_LEN)) ? r.linePtr : 10'(LINE_LEN - 1)];
    if (storeEn && !r.skipLine) begin
      lineMem[r.linePtr] <= inPix;
    end
  end

  assign lumaDiff = field1Bus.y[7:4] > field2Bus.y[7:4]
                  ? field1Bus.y[7:4] - field2Bus.y[7:4]
                  : field2Bus.y[7:4] - field1Bus.y[7:4];

  // ----------------------------------------------------------------
  // Core next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [5:0]        zsum;
    logic [3:0]        nib;
    logic [8:0]        dNow;
    logic [8:0]        tapSum;
    logic signed [9:0] slope;
    logic signed [9:0] step;
    logic [4:0]        lim;
    logic [4:0]        kSel;
    logic [7:0]        uvMix;
    logic [7:0]        ctiVal;
    // Every local gets a value first so that no path leaves a latch.
    zsum = '0;
    nib = '0;
    dNow = '0;
    tapSum = '0;
    slope = '0;
    step = '0;
    lim = '0;
    kSel = '0;
    uvMix = '0;
    ctiVal = '0;
    c = r;
    c.wrSync   = {r.wrSync[1:0], lr.wrTgl};
    c.rdSync   = {r.rdSync[1:0], lr.rdTgl};
    c.rstrSync = {r.rstrSync[1:0], linkResetStrobe};
    c.blnDly   = {r.blnDly[BLN_SHIFT-2:0], blankN};
    c.blnPrev  = blnInt;
    c.winPrev  = win;
    c.re1Sh    = {r.re1Sh[RE_SHIFT-2:0], bank1ReadReqIn};
    c.re2Sh    = {r.re2Sh[RE_SHIFT-2:0], bank2ReadReqIn};
    c.fbPipe   = {r.fbPipe[FB_DELAY-2:0], field1Bus};

    // Register writes; unknown addresses are dropped, grey and CTI keep bits 7:4 and format bits 7:2.
    if (wrEvent) begin
      if (lr.wrAddr == ADDR_FMT) begin
        c.ctrl.fmt = lr.wrData & MASK_FMT;
      end else if (lr.wrAddr == ADDR_GREY) begin
        c.ctrl.grey = lr.wrData & MASK_GREY;
      end else if (lr.wrAddr == ADDR_RE) begin
        c.ctrl.reTim = lr.wrData;
      end else if (lr.wrAddr == ADDR_ZOOM) begin
        c.ctrl.zoom = lr.wrData;
      end else if (lr.wrAddr == ADDR_CTI) begin
        c.ctrl.cti = lr.wrData & MASK_CTI;
      end else if (lr.wrAddr == ADDR_PEAK) begin
        c.ctrl.peak = lr.wrData;
      end else if (lr.wrAddr[7:2] == ADDR_MUX[7:2]) begin
        c.ctrl.fieldOneSel = lr.wrAddr[0];
        c.ctrl.medianSel   = lr.wrAddr[1];
      end
    end

    // Line pointer restarts with the window and stops at the end.
    if (!win) begin
      c.linePtr = '0;
    end else if (storeEn) begin
      c.linePtr = r.linePtr + 10'd1;
    end

    // Zoom phase steps once a line; its carry repeats the stored line.
    if (winRise) begin
      zsum       = {1'b0, r.zoomAcc} + {1'b0, r.ctrl.zoom[ZM_LSB +: 5]};
      c.zoomAcc  = zsum[4:0];
      c.skipLine = zsum[5];
    end

    // Chroma phase counter, aligned by the blanking rise.
    c.phase = blnRise ? 2'd0 : r.phase + 2'd1;
    for (int ch = 0; ch < 2; ch++) begin
      nib = (ch == 0) ? inPix.uv : lineRd.uv;
      c.uAcc[ch] = {r.uAcc[ch][5:0], nib[3:2]};
      c.vAcc[ch] = {r.vAcc[ch][5:0], nib[1:0]};
      if (r.phase == 2'd3) begin
        c.uHold[ch] = {r.uAcc[ch][5:0], nib[3:2]};
        c.vHold[ch] = {r.vAcc[ch][5:0], nib[1:0]};
      end
      uvSeq[ch] = r.phase[1] ? r.vHold[ch] : r.uHold[ch];
    end

    // Mixers between the current and the delayed line.
    c.pixDly = inPix;
    c.yMix   = mixF(r.pixDly.y, lineRd.y, kCoef);
    uvMix    = mixF(uvSeq[0], uvSeq[1], kCoef);

    // Transient improver on the shared U/V stream.
    c.taps  = {r.taps[CTI_TAPS-2:0], uvMix};
    dNow    = {1'b0, absDiff(r.taps[0], r.taps[4])} + {1'b0, absDiff(r.taps[2], r.taps[6])};
    c.dPrev = dNow;
    slope   = $signed({1'b0, dNow}) - $signed({1'b0, r.dPrev});
    step    = slope >>> (2'd3 - r.ctrl.cti[CTI_GAIN +: 2]);
    lim     = 5'd3 * ({3'b000, r.ctrl.cti[CTI_RANGE +: 2]} + 5'd1);
    if (step > $signed({5'b00000, lim})) begin
      step = $signed({5'b00000, lim});
    end else if (step < -$signed({5'b00000, lim})) begin
      step = -$signed({5'b00000, lim});
    end
    kSel   = 5'(10'(CTI_CENTER) + step);
    tapSum = {1'b0, r.taps[kSel]} + {1'b0, r.taps[kSel + 5'd1]};
    ctiVal = tapSum[8:1];
    if (r.phase[1]) begin
      c.vCti = ctiVal;
    end else begin
      c.uCti = ctiVal;
    end

    // Correlation: accumulate, copy on strobe in blanking, clear on read.
    if (blnInt && win) begin
      c.acc = r.acc + ACC_W'(lumaDiff);
    end
    if (rdEvent) begin
      c.corr = '0;
    end
    if (rstrRise && !blnInt) begin
      c.corr = r.acc[ACC_W-1 -: 16];
      c.acc  = '0;
    end

    // Output insertion: blank, then grey or hold, else video.
    if (!blnInt) begin
      c.out.y = r.ctrl.zoom[ZM_BLACK16] ? BLACK_HI : 8'h00;
      c.out.u = 8'h00;
      c.out.v = 8'h00;
    end else if (!win) begin
      if (!r.ctrl.zoom[ZM_PIXREP]) begin
        c.out.y = r.ctrl.grey;
        c.out.u = 8'h00;
        c.out.v = 8'h00;
      end
    end else begin
      c.out.y = r.yMix;
      c.out.u = r.uCti;
      c.out.v = r.vCti;
    end
  end

  // Core state register.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
    end else begin
      r <= c;
    end
  end

  // ----------------------------------------------------------------
  // Assertions and covers
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  a_re2_delay: assert property ((r.ctrl.reTim[5:3] == 3'd0 && $past(r.ctrl.reTim, 6) == r.ctrl.reTim)
    |-> bank2ReadReqOut == $past(bank2ReadReqIn, 5)) else $error("read enable two delay wrong");
  a_line_hold: assert property (win && r.linePtr == 10'(LINE_LEN) ##1 win
    |-> r.linePtr == 10'(LINE_LEN)) else $error("line store moved past end");
  a_fb_tristate: assert property (linkResetStrobe |-> !feedbackOe)
    else $error("feedback driven during strobe");
  a_fb_delay: assert property (##4 1 |-> feedbackBus == $past(field1Bus, 4))
    else $error("feedback delay wrong");
  a_blank_level: assert property (!blnInt |=> videoOut.u == 8'h00 && videoOut.v == 8'h00
    && (videoOut.y == 8'h00 || videoOut.y == BLACK_HI)) else $error("blanking level wrong");
  a_grey_insert: assert property (blnInt && !win && !r.ctrl.zoom[ZM_PIXREP]
    |=> videoOut.y == $past(r.ctrl.grey)) else $error("grey not inserted");
  a_hold_value: assert property (blnInt && !win && r.ctrl.zoom[ZM_PIXREP]
    |=> $stable(videoOut)) else $error("side panel not held");
  a_corr_copy: assert property (rstrRise && !blnInt
    |=> r.corr == $past(r.acc[ACC_W-1 -: 16]) && r.acc == '0) else $error("correlation copy wrong");
  a_chroma_phase: assert property (blnRise |=> r.phase == 2'd0 ##1 r.phase == 2'd1 || blnRise)
    else $error("chroma phase not aligned");

  a_read_clear: assert property (rdEvent && !(rstrRise && !blnInt) |=> r.corr == 16'h0000)
    else $error("correlation not cleared");
  a_ptr_restart: assert property (!win |=> r.linePtr == 10'd0) else $error("line pointer not restarted");
  a_re1_delay: assert property ((r.ctrl.reTim[2:0] == 3'd0 && $past(r.ctrl.reTim, 6) == r.ctrl.reTim)
    |-> bank1ReadReqOut == ($past(bank1ReadReqIn, 5) & ~r.skipLine)) else $error("read enable one delay wrong");

  c_corr_copy: cover property (rstrRise && !blnInt);
  c_read_xfer: cover property (rdEvent);
  c_zoom_skip: cover property (winRise ##1 r.skipLine);
  c_line_full: cover property (win && r.linePtr == 10'(LINE_LEN));

endmodule : vbd_backend

// [test/vbd_host_model.sv]
// Host model that drives the two-wire serial link and the link reset strobe.
`timescale 1ns/1ps
module vbd_host_model (
  output logic      hostSerialClock,
  output logic      hostSerialDataIn,
  input  wire logic hostSerialDataOut,
  input  wire logic hostSerialDataOe,
  output logic      linkResetStrobe
);
  localparam int HALF = 15;
  logic hostEn;
  logic hostBit;
  logic idleBit;

  // Released line shows a toggling pattern, never the last value.
  initial begin
    hostSerialClock = 1'b0;
    hostEn          = 1'b0;
    hostBit         = 1'b0;
    idleBit         = 1'b0;
    linkResetStrobe = 1'b0;
  end
  always #(HALF) idleBit = ~idleBit;
  assign hostSerialDataIn = hostSerialDataOe ? hostSerialDataOut : (hostEn ? hostBit : idleBit);

  // ---------------------------------------------------------------
  // One transfer: clock runs only here, data changes after falls.
  // ---------------------------------------------------------------
  task automatic xfer(input logic [7:0] addr, input logic [7:0] wdata, input bit isRead,
                      output logic [7:0] rdata);
    int i;
    rdata = 8'h00;
    for (i = 0; i < 16; i++) begin
      hostEn  = !(isRead && i >= 8);
      hostBit = (i < 8) ? addr[i] : wdata[i-8];
      #(HALF) hostSerialClock = 1'b1;
      #(HALF) hostSerialClock = 1'b0;
      if (isRead && i >= 7 && i < 15) rdata[i-7] = hostSerialDataIn;
    end
    hostEn = 1'b0;
    #200;
  endtask : xfer

  // Strobe changes only while the core clock runs, at any phase.
  task automatic setStrobe(input logic v);
    #7 linkResetStrobe = v;
    #200;
  endtask : setStrobe
endmodule : vbd_host_model

// [test/tb.sv]
// Self-checking testbench of the video back-end datapath.
`timescale 1ns/1ps
module tb;
  import vbd_pkg::*;
  logic        core_clk;
  logic        arst_n;
  logic        hostSerialClock, hostSerialDataIn, hostSerialDataOut, hostSerialDataOe;
  logic        linkResetStrobe, blankN, bank1ReadReqIn, bank2ReadReqIn;
  logic        bank1ReadReqOut, bank2ReadReqOut, feedbackOe;
  vbd_pix_t    field1Bus, field2Bus, feedbackBus;
  vbd_yuv_t    videoOut;
  int          fails, n_checks, cycles;
  logic [11:0] hist [0:15];
  logic [7:0]  rd, lo, hi;
  int          n1, n2;

  vbd_backend dut (.core_clk(core_clk), .arst_n(arst_n), .hostSerialClock(hostSerialClock),
    .hostSerialDataIn(hostSerialDataIn), .hostSerialDataOut(hostSerialDataOut),
    .hostSerialDataOe(hostSerialDataOe), .linkResetStrobe(linkResetStrobe), .blankN(blankN),
    .bank1ReadReqIn(bank1ReadReqIn), .bank2ReadReqIn(bank2ReadReqIn),
    .bank1ReadReqOut(bank1ReadReqOut), .bank2ReadReqOut(bank2ReadReqOut), .field1Bus(field1Bus),
    .field2Bus(field2Bus), .feedbackBus(feedbackBus), .feedbackOe(feedbackOe), .videoOut(videoOut));

  vbd_host_model host (.hostSerialClock(hostSerialClock), .hostSerialDataIn(hostSerialDataIn),
    .hostSerialDataOut(hostSerialDataOut), .hostSerialDataOe(hostSerialDataOe),
    .linkResetStrobe(linkResetStrobe));

  // Clock and a cycle ceiling that cuts a hang short.
  initial core_clk = 1'b0;
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles >= 20000) begin
      fails++;
      stop_test();
    end
  end

  // ---------------------------------------------------------------
  // Shared tasks.
  // ---------------------------------------------------------------
  task automatic check(input logic [23:0] got, input logic [23:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
      fails++;
    end
  endtask : check

  task automatic hostWrite(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] dummy;
    host.xfer(a, d, 1'b0, dummy);
    cyc(1);
  endtask : hostWrite

  task automatic hostRead(input logic [7:0] a, output logic [7:0] d);
    host.xfer(a, 8'h00, 1'b1, d);
    cyc(1);
  endtask : hostRead

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  // Correlation window: fields active for a fixed span, then strobe in blanking.
  task automatic measure(input logic [7:0] y1, input logic [7:0] y2);
    field1Bus = '{y: y1, uv: 4'h0};
    field2Bus = '{y: y2, uv: 4'h0};
    blankN = 1'b1;
    bank1ReadReqIn = 1'b1;
    cyc(400);
    blankN = 1'b0;
    bank1ReadReqIn = 1'b0;
    cyc(20);
    host.setStrobe(1'b1);
    host.setStrobe(1'b0);
    hostRead(ADDR_CLO, lo);
    hostRead(ADDR_CHI, hi);
  endtask : measure

  // ---------------------------------------------------------------
  // Main sequence.
  // ---------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    blankN = 1'b0;
    bank1ReadReqIn = 1'b0;
    bank2ReadReqIn = 1'b0;
    field1Bus = '0;
    field2Bus = '0;
    fails = 0;
    n_checks = 0;
    cycles = 0;
    cyc(2);
    arst_n = 1'b1;
    cyc(2);
    check(videoOut, 24'h000000, "reset video");
    check({23'h0, feedbackOe}, 24'h1 ^ 24'h1, "reset feedback enable");
    $display("test reset done");

    // Feedback bus delay, strobe override, ignored bits and addresses.
    hostWrite(ADDR_FMT, 8'h83);
    check({23'h0, feedbackOe}, 24'h000001, "feedback enable");
    for (int i = 0; i < 14; i++) begin
      cyc(1);
      if (i >= 4) check({12'h0, feedbackBus}, {12'h0, hist[i-4]}, "feedback data");
      hist[i] = 12'(i * 37 + 5);
      field1Bus = vbd_pix_t'(hist[i]);
    end
    host.setStrobe(1'b1);
    check({23'h0, feedbackOe}, 24'h000000, "strobe three-state");
    host.setStrobe(1'b0);
    hostWrite(8'h09, 8'h00);
    check({23'h0, feedbackOe}, 24'h000001, "undefined address");
    $display("test feedback done");

    // Blanking levels and grey side panel.
    cyc(6);
    check(videoOut, 24'h000000, "blank level");
    hostWrite(ADDR_ZOOM, 8'h04);
    cyc(6);
    check(videoOut, 24'h100000, "raised blank level");
    hostWrite(ADDR_ZOOM, 8'h00);
    hostWrite(ADDR_GREY, 8'hAF);
    blankN = 1'b1;
    cyc(12);
    check(videoOut, 24'hA00000, "grey panel");
    hostWrite(ADDR_ZOOM, 8'h02);
    cyc(4);
    check(videoOut, 24'hA00000, "held panel");
    hostWrite(ADDR_ZOOM, 8'h00);
    $display("test panels done");

    // Read request delays for every setting, then inversion.
    for (int d = 0; d < 4; d++) begin
      hostWrite(ADDR_RE, 8'(d | (d << 3)));
      n1 = 0;
      n2 = 0;
      bank1ReadReqIn = 1'b1;
      bank2ReadReqIn = 1'b1;
      for (int n = 1; n <= 12; n++) begin
        cyc(1);
        if (bank1ReadReqOut === 1'b1 && n1 == 0) n1 = n;
        if (bank2ReadReqOut === 1'b1 && n2 == 0) n2 = n;
      end
      check(24'(n1), 24'(RE_BASE + d), "bank1 delay");
      check(24'(n2), 24'(RE_BASE + d), "bank2 delay");
      bank1ReadReqIn = 1'b0;
      bank2ReadReqIn = 1'b0;
      cyc(12);
    end
    hostWrite(ADDR_RE, 8'h24);
    cyc(10);
    check({22'h0, bank1ReadReqOut, bank2ReadReqOut}, 24'h000003, "inverted requests");
    hostWrite(ADDR_RE, 8'h00);
    $display("test read requests done");

    // Correlation: clear, equal fields, differing fields, clear on read.
    blankN = 1'b0;
    measure(8'h00, 8'h00);
    measure(8'h5A, 8'h53);
    check({8'h0, hi, lo}, 24'h000000, "equal upper nibbles");
    measure(8'hF0, 8'h00);
    check({8'h0, hi, lo}, 24'h000017, "differing fields");
    hostRead(ADDR_CLO, rd);
    check({16'h0, rd}, 24'h000000, "cleared after read");
    $display("test correlation done");
    stop_test();
  end
endmodule : tb
